/* File: hw/fsps_pkg.sv */
// Shared constants and types for the flash status and power-state block
package fsps_pkg;
    // Clock and timing
    localparam int CLK_MHZ        = 50;
    localparam int OSC_TIME_MS    = 10;
    localparam int SETUP_TIME_MS  = 10;
    localparam int OSC_CYCLES     = OSC_TIME_MS * 1000 * CLK_MHZ;
    localparam int SETUP_CYCLES   = SETUP_TIME_MS * 1000 * CLK_MHZ;
    localparam int WAIT_UNIT      = 256;
    localparam int CNT_W          = 20;
    localparam int SETTLE_W       = 12;

    // Programmer command codes
    localparam logic [7:0] CMD_STATUS_READ = 8'h71;

    // Register indices on the software port
    localparam logic [1:0] ADDR_FLASH_POWER_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_SYSTEM_CONTROL_ONE  = 2'h1;
    localparam logic [1:0] ADDR_STATE               = 2'h2;
    localparam logic [1:0] ADDR_RETURN_CODE         = 2'h3;

    // Field positions
    localparam int INHIBIT_BIT    = 0;
    localparam int WAIT_SEL_LSB   = 0;
    localparam int WAIT_SEL_W     = 3;

    // Reset values
    localparam logic       INHIBIT_RESET  = 1'b0;
    localparam logic [2:0] WAIT_SEL_RESET = 3'h7;
    localparam logic [7:0] RCODE_RESET    = 8'h00;

    // Return code bit positions
    localparam int RC_ABNORMAL = 7;
    localparam int RC_CMD_ERR  = 6;
    localparam int RC_PROG_ERR = 5;
    localparam int RC_ERASE_ERR = 4;
    localparam int RC_OVERCOUNT = 1;
    localparam int RC_ADDR_ERR = 0;

    typedef enum logic [2:0] {
        FSPS_ACTIVE, FSPS_SUBACTIVE, FSPS_SLEEP, FSPS_SUBSLEEP, FSPS_STANDBY, FSPS_WATCH
    } fsps_lsi_mode_t;

    typedef enum logic [1:0] {
        FSPS_FL_NORMAL, FSPS_FL_POWERDOWN, FSPS_FL_STANDBY
    } fsps_flash_state_t;

    typedef enum logic [1:0] {FSPS_BOOT_OSC, FSPS_BOOT_SETUP, FSPS_BOOT_READY} fsps_boot_t;

    typedef enum logic [1:0] {FSPS_MD_READ, FSPS_MD_STATUS, FSPS_MD_POLL} fsps_out_mode_t;
endpackage

/* File: hw/fsps_top.sv */
// Flash status reporting, programmer-mode entry and flash power states
//
// Overview of operation
// - Status byte: abnormal, command, program, erase errors on lines 7..4; reset 0.
// - Line 1 reports exceeded program or erase repetitions.
// - Line 0 reports an invalid address.
// - Polling byte: line 7 low while running, high when done; lines 0-5 zero.
// - On completion line 6 high means normal end; 7 low with 6 high never.
// - Command cycles are ignored during oscillator settling and setup period.
// - After setup period the device enters memory read mode and awaits commands.
// - Flash state follows LSI mode; subactive uses inhibit bit to pick state.
// - Low-power inhibit bit resets to 0.
// - Power-down keeps array readable; full speed only in normal state.
// - Standby halts all flash circuits; no access until normal or power-down again.
// - Return code holds until a command other than status read is written.
// - Polling flags hold until a command other than status read is written.
`timescale 1ns/1ps
module fsps_top import fsps_pkg::*; #(
    parameter int OSC_CNT   = OSC_CYCLES,
    parameter int SETUP_CNT = SETUP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       ce_n_pin,
    input  wire logic       oe_n_pin,
    input  wire logic       we_n_pin,
    input  wire logic [7:0] data_in_pin,
    output logic      [7:0] data_out,
    output logic            data_oe_n,
    output logic            cmd_valid,
    output logic      [7:0] cmd_data,
    input  wire logic       op_running,
    input  wire logic       op_done,
    input  wire logic       err_cmd,
    input  wire logic       err_prog,
    input  wire logic       err_erase,
    input  wire logic       err_overcount,
    input  wire logic       err_addr,
    input  wire logic [2:0] lsi_mode,
    output logic      [1:0] flash_state,
    output logic            flash_read_en,
    output logic            flash_fullspeed_en,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata
);
    localparam logic [CNT_W-1:0] OSC_LAST   = CNT_W'(OSC_CNT - 1);
    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CNT - 1);

    // Settling cycles for a given wait select code
    function automatic logic [SETTLE_W-1:0] settle_cycles(input logic [2:0] sel);
        settle_cycles = SETTLE_W'((32'(sel) + 32'd1) * WAIT_UNIT);
    endfunction

    // Pin synchronisers
    logic [10:0] sync1_r, sync2_r;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_r <= 11'h7FF;
            sync2_r <= 11'h7FF;
        end else begin
            sync1_r <= {ce_n_pin, oe_n_pin, we_n_pin, data_in_pin};
            sync2_r <= sync1_r;
        end
    end
    logic       ce_n_s, oe_n_s, we_n_s;
    logic [7:0] din_s;
    assign {ce_n_s, oe_n_s, we_n_s, din_s} = sync2_r;

    // Boot sequencer: oscillator settling, setup period, then command wait
    fsps_boot_t       boot_r, boot_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    always_comb begin
        boot_nxt = boot_r;
        cnt_nxt  = cnt_r + CNT_W'(1);
        case (boot_r)
            FSPS_BOOT_OSC: begin
                if (cnt_r == OSC_LAST) begin
                    boot_nxt = FSPS_BOOT_SETUP;
                    cnt_nxt  = '0;
                end
            end
            FSPS_BOOT_SETUP: begin
                if (cnt_r == SETUP_LAST) begin
                    boot_nxt = FSPS_BOOT_READY;
                    cnt_nxt  = '0;
                end
            end
            FSPS_BOOT_READY: cnt_nxt = '0;
            default: begin
                boot_nxt = FSPS_BOOT_OSC;
                cnt_nxt  = '0;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            boot_r <= FSPS_BOOT_OSC;
            cnt_r  <= '0;
        end else begin
            boot_r <= boot_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // Command write detection on write-enable rising edge with chip enable low
    logic we_prev_r;
    logic cmd_wr;
    assign cmd_wr = (boot_r == FSPS_BOOT_READY) && we_n_s && !we_prev_r && !ce_n_s;
    always_ff @(posedge clk) begin
        if (!reset_n) we_prev_r <= 1'b1;
        else          we_prev_r <= we_n_s;
    end

    // Output mode, return code and polling flags
    fsps_out_mode_t mode_r, mode_nxt;
    logic [7:0]     rcode_r, rcode_nxt;
    logic           pdone_r, pdone_nxt, pok_r, pok_nxt;
    logic           any_err;
    assign any_err = err_cmd | err_prog | err_erase | err_overcount | err_addr;
    always_comb begin
        mode_nxt  = mode_r;
        rcode_nxt = rcode_r;
        pdone_nxt = pdone_r;
        pok_nxt   = pok_r;
        if (cmd_wr) begin
            if (din_s == CMD_STATUS_READ) begin
                mode_nxt = FSPS_MD_STATUS;
            end else begin
                mode_nxt  = FSPS_MD_READ;
                rcode_nxt = RCODE_RESET;
                pdone_nxt = 1'b0;
                pok_nxt   = 1'b0;
            end
        end
        if (boot_r == FSPS_BOOT_SETUP && cnt_r == SETUP_LAST) mode_nxt = FSPS_MD_READ;
        if (op_running && mode_r == FSPS_MD_READ) mode_nxt = FSPS_MD_POLL;
        if (op_done) begin
            // Completion wins over a clear in the same cycle
            rcode_nxt[RC_ABNORMAL]  = any_err;
            rcode_nxt[RC_CMD_ERR]   = err_cmd;
            rcode_nxt[RC_PROG_ERR]  = err_prog;
            rcode_nxt[RC_ERASE_ERR] = err_erase;
            rcode_nxt[3:2]          = 2'h0;
            rcode_nxt[RC_OVERCOUNT] = err_overcount;
            rcode_nxt[RC_ADDR_ERR]  = err_addr;
            pdone_nxt = 1'b1;
            pok_nxt   = !any_err;
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_r  <= FSPS_MD_READ;
            rcode_r <= RCODE_RESET;
            pdone_r <= 1'b0;
            pok_r   <= 1'b0;
        end else begin
            mode_r  <= mode_nxt;
            rcode_r <= rcode_nxt;
            pdone_r <= pdone_nxt;
            pok_r   <= pok_nxt;
        end
    end

    // Data line drive and command hand-off to the program/erase engine
    logic [7:0] dout_nxt;
    logic       doe_n_nxt;
    always_comb begin
        dout_nxt  = 8'h00;
        doe_n_nxt = 1'b1;
        if (!ce_n_s && !oe_n_s) begin
            if (mode_r == FSPS_MD_STATUS) begin
                dout_nxt  = rcode_r;
                doe_n_nxt = 1'b0;
            end else if (mode_r == FSPS_MD_POLL) begin
                dout_nxt  = {pdone_r, pdone_r & pok_r, 6'h00};
                doe_n_nxt = 1'b0;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b1;
            cmd_valid <= 1'b0;
            cmd_data  <= 8'h00;
        end else begin
            data_out  <= dout_nxt;
            data_oe_n <= doe_n_nxt;
            cmd_valid <= cmd_wr;
            cmd_data  <= cmd_wr ? din_s : cmd_data;
        end
    end

    // Software registers
    logic       inhibit_r, inhibit_nxt;
    logic [2:0] wsel_r, wsel_nxt;
    logic [7:0] rdata_nxt;
    logic       settle_busy_r;
    always_comb begin
        inhibit_nxt = inhibit_r;
        wsel_nxt    = wsel_r;
        if (reg_wr && reg_addr == ADDR_FLASH_POWER_CONTROL) inhibit_nxt = reg_wdata[INHIBIT_BIT];
        if (reg_wr && reg_addr == ADDR_SYSTEM_CONTROL_ONE) begin
            wsel_nxt = reg_wdata[WAIT_SEL_LSB +: WAIT_SEL_W];
        end
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_FLASH_POWER_CONTROL: rdata_nxt = {7'h00, inhibit_r};
                ADDR_SYSTEM_CONTROL_ONE:  rdata_nxt = {5'h00, wsel_r};
                ADDR_STATE:               rdata_nxt = {1'b0, settle_busy_r, mode_r, boot_r,
                                                       flash_state};
                ADDR_RETURN_CODE:         rdata_nxt = rcode_r;
                default:                  rdata_nxt = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            inhibit_r <= INHIBIT_RESET;
            wsel_r    <= WAIT_SEL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            inhibit_r <= inhibit_nxt;
            wsel_r    <= wsel_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // Flash operating state from LSI mode, with settling on return to normal
    logic [1:0]          fstate_nxt;
    logic [SETTLE_W-1:0] settle_r, settle_nxt;
    logic                rd_en_nxt, fs_en_nxt;
    always_comb begin
        case (lsi_mode)
            FSPS_ACTIVE, FSPS_SLEEP: fstate_nxt = FSPS_FL_NORMAL;
            FSPS_SUBACTIVE: fstate_nxt = inhibit_r ? FSPS_FL_NORMAL : FSPS_FL_POWERDOWN;
            default: fstate_nxt = FSPS_FL_STANDBY;
        endcase
        settle_nxt = (settle_r != '0) ? settle_r - SETTLE_W'(1) : settle_r;
        if (fstate_nxt == FSPS_FL_NORMAL && flash_state != FSPS_FL_NORMAL) begin
            settle_nxt = settle_cycles(wsel_r);
        end else if (fstate_nxt != FSPS_FL_NORMAL) begin
            settle_nxt = '0;
        end
        fs_en_nxt = (fstate_nxt == FSPS_FL_NORMAL) && (settle_nxt == '0);
        rd_en_nxt = fs_en_nxt || (fstate_nxt == FSPS_FL_POWERDOWN);
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flash_state        <= FSPS_FL_NORMAL;
            settle_r           <= '0;
            settle_busy_r      <= 1'b0;
            flash_read_en      <= 1'b0;
            flash_fullspeed_en <= 1'b0;
        end else begin
            flash_state        <= fstate_nxt;
            settle_r           <= settle_nxt;
            settle_busy_r      <= settle_nxt != '0;
            flash_read_en      <= rd_en_nxt;
            flash_fullspeed_en <= fs_en_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_status_bits;
        !data_oe_n && $past(mode_r) == FSPS_MD_STATUS |-> data_out[3:2] == 2'h0;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status undefined bits set");

    property p_rc_over;
        op_done |=> rcode_r[RC_OVERCOUNT] == $past(err_overcount);
    endproperty
    a_rc_over: assert property (p_rc_over) else $error("overcount bit wrong");

    property p_rc_addr;
        op_done |=> rcode_r[RC_ADDR_ERR] == $past(err_addr);
    endproperty
    a_rc_addr: assert property (p_rc_addr) else $error("address error bit wrong");

    property p_poll_low;
        !data_oe_n && $past(mode_r) == FSPS_MD_POLL |-> data_out[5:0] == 6'h00;
    endproperty
    a_poll_low: assert property (p_poll_low) else $error("poll low bits set");

    property p_poll_combo;
        !data_oe_n && $past(mode_r) == FSPS_MD_POLL |-> !(data_out[6] && !data_out[7]);
    endproperty
    a_poll_combo: assert property (p_poll_combo) else $error("undefined poll code");

    property p_ignore;
        boot_r != FSPS_BOOT_READY |=> !cmd_valid;
    endproperty
    a_ignore: assert property (p_ignore) else $error("command taken during setup");

    property p_enter_read;
        boot_r == FSPS_BOOT_SETUP && cnt_r == SETUP_LAST
            |=> boot_r == FSPS_BOOT_READY && mode_r == FSPS_MD_READ;
    endproperty
    a_enter_read: assert property (p_enter_read) else $error("no read mode after setup");

    property p_subactive;
        lsi_mode == FSPS_SUBACTIVE && $stable(inhibit_r)
            |=> flash_state == ($past(inhibit_r) ? FSPS_FL_NORMAL : FSPS_FL_POWERDOWN);
    endproperty
    a_subactive: assert property (p_subactive) else $error("subactive state wrong");

    property p_standby;
        flash_state == FSPS_FL_STANDBY |-> !flash_read_en && !flash_fullspeed_en;
    endproperty
    a_standby: assert property (p_standby) else $error("access in standby");

    property p_hold_rc;
        !op_done && !cmd_wr |=> $stable(rcode_r) && $stable(pdone_r);
    endproperty
    a_hold_rc: assert property (p_hold_rc) else $error("status changed w/o cause");

    property p_drive;
        !data_oe_n |-> $past(!ce_n_s && !oe_n_s);
    endproperty
    a_drive: assert property (p_drive) else $error("data driven without enables");
endmodule // fsps_top

/* File: tb/fsps_prog_model.sv */
// External parallel programmer model driving command and read cycles
`timescale 1ns/1ps
module fsps_prog_model import fsps_pkg::*; (
    input  wire logic       clk,
    output logic            ce_n_pin,
    output logic            oe_n_pin,
    output logic            we_n_pin,
    output logic      [7:0] data_in_pin,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    input  wire logic       cmd_valid
);
    // Idle pins: deselected, data lines show a non-constant pattern
    initial begin
        ce_n_pin    = 1'b1;
        oe_n_pin    = 1'b1;
        we_n_pin    = 1'b1;
        data_in_pin = 8'h5A;
    end

    // One command write; seen reports whether the block took it
    task automatic write_cmd(input logic [7:0] b, output logic seen);
        seen = 1'b0;
        @(posedge clk);
        ce_n_pin    <= 1'b0;
        we_n_pin    <= 1'b0;
        data_in_pin <= b;
        repeat (3) @(posedge clk);
        we_n_pin <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (cmd_valid === 1'b1) seen = 1'b1;
        end
        @(posedge clk);
        ce_n_pin    <= 1'b1;
        data_in_pin <= ~b;                                      // Data lines driven to the inverse of the command byte
        if (b == CMD_STATUS_READ) repeat (1000) @(posedge clk);
    endtask

    // One read cycle with chip and output enable low
    task automatic read_byte(output logic [7:0] v, output logic drove);
        drove = 1'b0;
        @(posedge clk);
        ce_n_pin <= 1'b0;
        oe_n_pin <= 1'b0;
        for (int i = 0; i < 8 && !drove; i++) begin
            @(posedge clk);
            #1;
            if (data_oe_n === 1'b0) drove = 1'b1;
        end
        v = data_out;
        @(posedge clk);
        ce_n_pin <= 1'b1;
        oe_n_pin <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule // fsps_prog_model

/* File: tb/fsps_tb_top.sv */
// Self-checking bench for the flash status and power-state block
`timescale 1ns/1ps
module fsps_tb_top import fsps_pkg::*; ;
    localparam logic [7:0] ERASE_CMD = 8'h20;
    localparam logic [7:0] PROG_CMD  = 8'h40;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       op_running = 1'b0;
    logic       op_done = 1'b0;
    logic       err_cmd = 1'b0, err_prog = 1'b0, err_erase = 1'b0;
    logic       err_overcount = 1'b0, err_addr = 1'b0;
    logic [2:0] lsi_mode = 3'h0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0, reg_rd = 1'b0;
    wire        ce_n_pin, oe_n_pin, we_n_pin, data_oe_n, cmd_valid;
    wire        flash_read_en, flash_fullspeed_en;
    wire  [7:0] data_in_pin, data_out, cmd_data, reg_rdata;
    wire  [1:0] flash_state;
    int         fail_count = 0;
    int         checked = 0;

    // Clock generation
    always #10 clk = ~clk;

    // Block under test with short boot counts
    fsps_top #(.OSC_CNT(20), .SETUP_CNT(30)) u_fsps_top (
        .clk(clk), .reset_n(reset_n), .ce_n_pin(ce_n_pin), .oe_n_pin(oe_n_pin),
        .we_n_pin(we_n_pin), .data_in_pin(data_in_pin), .data_out(data_out),
        .data_oe_n(data_oe_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .op_running(op_running), .op_done(op_done), .err_cmd(err_cmd),
        .err_prog(err_prog), .err_erase(err_erase), .err_overcount(err_overcount),
        .err_addr(err_addr), .lsi_mode(lsi_mode), .flash_state(flash_state),
        .flash_read_en(flash_read_en), .flash_fullspeed_en(flash_fullspeed_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // Programmer on the far side of the pins
    fsps_prog_model u_fsps_prog_model (
        .clk(clk), .ce_n_pin(ce_n_pin), .oe_n_pin(oe_n_pin), .we_n_pin(we_n_pin),
        .data_in_pin(data_in_pin), .data_out(data_out), .data_oe_n(data_oe_n),
        .cmd_valid(cmd_valid));

    // Comparison, verdict and bus helpers
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("Counts: checked %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic send(input logic [7:0] b);
        logic seen;
        u_fsps_prog_model.write_cmd(b, seen);
        check("cmd_accepted", {7'h00, seen}, 8'h01);
        check("cmd_data", cmd_data, b);
    endtask

    task automatic read_pins(output logic [7:0] v);
        logic drove;
        u_fsps_prog_model.read_byte(v, drove);
        check("data_driven", {7'h00, drove}, 8'h01);
        check("data_released", {7'h00, data_oe_n}, 8'h01);
    endtask

    task automatic engine_done(input logic [4:0] e);
        @(posedge clk);
        {err_cmd, err_prog, err_erase, err_overcount, err_addr} <= e;
        op_done    <= 1'b1;
        op_running <= 1'b0;
        @(posedge clk);
        {err_cmd, err_prog, err_erase, err_overcount, err_addr} <= 5'h00;
        op_done <= 1'b0;
    endtask

    // Commands during oscillator and setup periods are dropped
    task automatic t_boot();
        logic [7:0] v;
        logic       seen;
        reg_read(ADDR_STATE, v);
        check("boot_osc", {6'h00, v[3:2]}, 8'h00);
        repeat (2) begin
            u_fsps_prog_model.write_cmd(PROG_CMD, seen);
            check("early_cmd", {7'h00, seen}, 8'h00);
        end
        for (int i = 0; i < 100 && v[3:2] !== 2'h2; i++) reg_read(ADDR_STATE, v);
        if (v[3:2] !== 2'h2) begin
            fail_count++;
            results();
        end
        check("mode_after_boot", {6'h00, v[5:4]}, 8'h00);
        $display("Test boot done");
    endtask

    // Return code for each error kind, its holding and clearing
    task automatic t_status();
        logic [4:0] errs [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
        logic [7:0] v;
        logic [7:0] exp;
        foreach (errs[i]) begin
            exp = {|errs[i], errs[i][4:2], 2'b00, errs[i][1:0]};
            send(ERASE_CMD);
            engine_done(errs[i]);
            send(CMD_STATUS_READ);
            read_pins(v);
            check("status_byte", v, exp);
        end
        reg_write(ADDR_RETURN_CODE, 8'hFF);
        send(ERASE_CMD);
        engine_done(5'h15);
        send(CMD_STATUS_READ);
        send(CMD_STATUS_READ);
        read_pins(v);
        check("status_held", v, 8'hD1);
        reg_read(ADDR_RETURN_CODE, v);
        check("return_code_reg", v, 8'hD1);
        send(PROG_CMD);
        send(CMD_STATUS_READ);
        read_pins(v);
        check("status_cleared", v, 8'h00);
        $display("Test status done");
    endtask

    // Polling flags during and after an operation
    task automatic t_poll();
        logic [7:0] v;
        send(PROG_CMD);
        op_running <= 1'b1;
        repeat (2) @(posedge clk);
        read_pins(v);
        check("poll_running", v, 8'h00);
        engine_done(5'h00);
        read_pins(v);
        check("poll_normal", v, 8'hC0);
        read_pins(v);
        check("poll_reread", v, 8'hC0);
        send(ERASE_CMD);
        op_running <= 1'b1;
        repeat (2) @(posedge clk);
        engine_done(5'h04);
        read_pins(v);
        check("poll_abnormal", v, 8'h80);
        $display("Test poll done");
    endtask

    // Flash state for every mode and inhibit value, then settle time
    task automatic t_power();
        logic [7:0] v;
        logic [1:0] st;
        int         n;
        reg_read(ADDR_FLASH_POWER_CONTROL, v);
        check("inhibit_reset", v, 8'h00);
        reg_read(ADDR_SYSTEM_CONTROL_ONE, v);
        check("wait_sel_reset", v, 8'h07);
        reg_write(ADDR_SYSTEM_CONTROL_ONE, 8'h03);
        for (int m = 0; m < 8; m++) begin
            for (int inh = 0; inh < 2; inh++) begin
                reg_write(ADDR_FLASH_POWER_CONTROL, 8'(inh));
                lsi_mode <= 3'(m);
                repeat (3) @(posedge clk);
                #1;
                st = (m == 0 || m == 2) ? 2'h0 : (m == 1) ? ((inh == 1) ? 2'h0 : 2'h1) : 2'h2;
                check("flash_state", {6'h00, flash_state}, {6'h00, st});
                if (st != 2'h0) begin
                    check("read_en", {7'h00, flash_read_en}, {7'h00, st == 2'h1});
                    check("fullspeed_off", {7'h00, flash_fullspeed_en}, 8'h00);
                end
            end
        end
        @(posedge clk);
        lsi_mode <= 3'h0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (flash_fullspeed_en !== 1'b1 && n < 1200);
        check("settle_min", {7'h00, n >= 4 * WAIT_UNIT}, 8'h01);
        check("settle_max", {7'h00, n <= 4 * WAIT_UNIT + 6}, 8'h01);
        check("settle_20us", {7'h00, n >= 1000}, 8'h01);
        check("read_en_normal", {7'h00, flash_read_en}, 8'h01);
        $display("Test power done");
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_boot();
        t_status();
        t_poll();
        t_power();
        results();
    end
endmodule // fsps_tb_top
